// ==== br1_hdr_regs.sv ====
// Purpose: Bridge header registers (timers, header type, bus numbers, I/O window) on AXI4-Lite
// Assumes: AXI4-Lite master on clk_sys_i; io_addr_i comes from logic on the same clock
// Notes: Upper 16 I/O address bits are not implemented here, so the window covers 64K only
// One write and one read at a time; readies stay low until the answer is taken
// Lock word gates the width flag only; the base field is still written while locked
// Unmapped words answer SLVERR with zero data, so probing software sees a clean error
`timescale 1ns/100ps
module br1_hdr_regs
	import br1_pkg::*;
#(
	parameter int unsigned AW = 8
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [AW-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [DATA_W-1:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [AW-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [DATA_W-1:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [31:0] io_addr_i,
	output br1_iowin_t io_win_o,
	output logic [7:0] up_bus_o,
	output logic [7:0] dn_bus_o,
	output logic [7:0] hi_bus_o,
	output logic io_fwd_hit_o
);

	localparam br1_cfg_t CFG_RST = '{
		up_bus: RST_BUS,
		dn_bus: RST_BUS,
		hi_bus: RST_BUS,
		io_base: RST_IO_BASE,
		io_limit: RST_IO_LIMIT,
		io_w32: RST_IO_W32,
		lock: RST_LOCK
	};

	br1_state_t s_q;
	br1_state_t s_d;

	function automatic logic [IDX_W-1:0] addr_idx(input logic [AW-1:0] a);
		addr_idx = a[IDX_W+1:2];
	endfunction

	function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
		case (idx)
			IDX_PLT, IDX_HDR, IDX_SELFTEST, IDX_BASE0, IDX_BASE1, IDX_UPBUS, IDX_DNBUS,
			IDX_HIBUS, IDX_DLT, IDX_IOLO, IDX_IOHI, IDX_DSTAT, IDX_LOCK: idx_mapped = 1'b1;
			default: idx_mapped = 1'b0;
		endcase
	endfunction

	// Constant registers other than the header type fall to the zero default
	function automatic logic [DATA_W-1:0] read_word(input br1_cfg_t c, input logic [IDX_W-1:0] idx);
		logic [DATA_W-1:0] w;
		w = '0;
		case (idx)
			IDX_HDR: w[7:0] = VAL_HDR;
			IDX_UPBUS: w[7:0] = c.up_bus;
			IDX_DNBUS: w[7:0] = c.dn_bus;
			IDX_HIBUS: w[7:0] = c.hi_bus;
			IDX_IOLO: begin
				w[IO_ADDR_LSB +: 4] = c.io_base;
				w[IO_WIDTH_BIT] = c.io_w32;
			end
			IDX_IOHI: begin
				w[IO_ADDR_LSB +: 4] = c.io_limit;
				w[IO_WIDTH_BIT] = c.io_w32;
			end
			IDX_LOCK: w[LOCK_BIT] = c.lock;
			default: w = '0;
		endcase
		read_word = w;
	endfunction

	// Base is 4KB aligned, limit extends through 0xFFF
	function automatic logic win_hit(input br1_cfg_t c, input logic [31:0] a);
		logic [31:0] lo;
		logic [31:0] hi;
		lo = {16'h0000, c.io_base, IO_BASE_LOW};
		hi = {16'h0000, c.io_limit, IO_LIMIT_LOW};
		win_hit = (a >= lo) && (a <= hi);
	endfunction

	logic wr_fire;
	assign wr_fire = s_q.aw_hold && s_q.w_hold && !s_q.bvalid;

	always_comb begin
		s_d = s_q;
		// Address and data are taken independently, in either order
		if (s_q.aw_rdy && s_axi_awvalid_i) begin
			s_d.aw_hold = 1'b1;
			s_d.wr_idx = addr_idx(s_axi_awaddr_i);
		end
		if (s_q.w_rdy && s_axi_wvalid_i) begin
			s_d.w_hold = 1'b1;
			s_d.wr_data = s_axi_wdata_i;
			s_d.wr_strb = s_axi_wstrb_i;
		end
		if (wr_fire) begin
			s_d.aw_hold = 1'b0;
			s_d.w_hold = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = idx_mapped(s_q.wr_idx) ? RESP_OKAY : RESP_SLVERR;
			// All stored fields live in byte lane 0
			if (s_q.wr_strb[0]) begin
				case (s_q.wr_idx)
					IDX_UPBUS: s_d.cfg.up_bus = s_q.wr_data[7:0];
					IDX_DNBUS: s_d.cfg.dn_bus = s_q.wr_data[7:0];
					IDX_HIBUS: s_d.cfg.hi_bus = s_q.wr_data[7:0];
					IDX_IOLO: begin
						s_d.cfg.io_base = s_q.wr_data[IO_ADDR_LSB +: 4];
						if (!s_q.cfg.lock) begin
							s_d.cfg.io_w32 = s_q.wr_data[IO_WIDTH_BIT];
						end
					end
					IDX_IOHI: s_d.cfg.io_limit = s_q.wr_data[IO_ADDR_LSB +: 4];
					IDX_LOCK: s_d.cfg.lock = s_q.wr_data[LOCK_BIT];
					default: s_d.cfg = s_q.cfg;
				endcase
			end
		end
		if (s_q.bvalid && s_axi_bready_i) begin
			s_d.bvalid = 1'b0;
		end
		// One write outstanding; ready drops until the response is taken
		s_d.aw_rdy = !s_d.aw_hold && !s_d.bvalid;
		s_d.w_rdy = !s_d.w_hold && !s_d.bvalid;
		if (s_q.ar_rdy && s_axi_arvalid_i) begin
			s_d.rvalid = 1'b1;
			s_d.rd_idx = addr_idx(s_axi_araddr_i);
			s_d.rdata = read_word(s_q.cfg, addr_idx(s_axi_araddr_i));
			s_d.rresp = idx_mapped(addr_idx(s_axi_araddr_i)) ? RESP_OKAY : RESP_SLVERR;
		end
		if (s_q.rvalid && s_axi_rready_i) begin
			s_d.rvalid = 1'b0;
		end
		s_d.ar_rdy = !s_d.rvalid;
		s_d.fwd_hit = win_hit(s_q.cfg, io_addr_i);
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '{
				cfg: CFG_RST,
				aw_rdy: 1'b0,
				w_rdy: 1'b0,
				aw_hold: 1'b0,
				w_hold: 1'b0,
				wr_idx: '0,
				wr_data: '0,
				wr_strb: '0,
				bvalid: 1'b0,
				bresp: RESP_OKAY,
				ar_rdy: 1'b0,
				rvalid: 1'b0,
				rd_idx: '0,
				rdata: '0,
				rresp: RESP_OKAY,
				fwd_hit: 1'b0
			};
		end else begin
			s_q <= s_d;
		end
	end

	assign s_axi_awready_o = s_q.aw_rdy;
	assign s_axi_wready_o = s_q.w_rdy;
	assign s_axi_bvalid_o = s_q.bvalid;
	assign s_axi_bresp_o = s_q.bresp;
	assign s_axi_arready_o = s_q.ar_rdy;
	assign s_axi_rvalid_o = s_q.rvalid;
	assign s_axi_rdata_o = s_q.rdata;
	assign s_axi_rresp_o = s_q.rresp;
	assign io_win_o.base = s_q.cfg.io_base;
	assign io_win_o.limit = s_q.cfg.io_limit;
	assign io_win_o.w32 = s_q.cfg.io_w32;
	assign up_bus_o = s_q.cfg.up_bus;
	assign dn_bus_o = s_q.cfg.dn_bus;
	assign hi_bus_o = s_q.cfg.hi_bus;
	assign io_fwd_hit_o = s_q.fwd_hit;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	// Byte-lane-0 write to a given index, seen one cycle later
	logic wr_lane0;
	assign wr_lane0 = wr_fire && s_q.wr_strb[0];

	a_plt_reads_zero: assert property (s_axi_rvalid_o && s_q.rd_idx == IDX_PLT |-> s_axi_rdata_o == '0)
		else $error("primary latency timer read not zero");
	a_hdr_reads_one: assert property (s_axi_rvalid_o && s_q.rd_idx == IDX_HDR |-> s_axi_rdata_o == 32'h00000001)
		else $error("header layout byte not 0x01");
	a_selftest_zero: assert property (s_axi_rvalid_o && s_q.rd_idx == IDX_SELFTEST |-> s_axi_rdata_o == '0)
		else $error("self test byte not zero");
	a_base_win_zero: assert property (s_axi_rvalid_o && (s_q.rd_idx == IDX_BASE0 || s_q.rd_idx == IDX_BASE1)
		|-> s_axi_rdata_o == '0)
		else $error("base window word not zero");
	a_upbus_write: assert property (wr_lane0 && s_q.wr_idx == IDX_UPBUS |=> up_bus_o == $past(s_q.wr_data[7:0]))
		else $error("upstream bus number not written");
	a_dnbus_write: assert property (wr_lane0 && s_q.wr_idx == IDX_DNBUS |=> dn_bus_o == $past(s_q.wr_data[7:0]))
		else $error("downstream bus number not written");
	a_hibus_write: assert property (wr_lane0 && s_q.wr_idx == IDX_HIBUS |=> hi_bus_o == $past(s_q.wr_data[7:0]))
		else $error("highest downstream bus not written");
	a_dlt_zero: assert property (s_axi_rvalid_o && s_q.rd_idx == IDX_DLT |-> s_axi_rdata_o == '0)
		else $error("downstream latency timer not zero");
	a_width_locked: assert property (s_q.cfg.lock && !$past(rst_i) |=> $stable(io_win_o.w32) || !$past(s_q.cfg.lock))
		else $error("width flag changed while locked");
	a_io_window_low_write: assert property (wr_lane0 && s_q.wr_idx == IDX_IOLO |=> io_win_o.base == $past(s_q.wr_data[7:4]))
		else $error("window low not written");
	a_io_window_high_write: assert property (wr_lane0 && s_q.wr_idx == IDX_IOHI
		|=> io_win_o.limit == $past(s_q.wr_data[7:4]) && $stable(io_win_o.w32))
		else $error("window high not written or width disturbed");
	a_width_mirror: assert property (s_axi_rvalid_o && s_q.rd_idx == IDX_IOHI
		|-> s_axi_rdata_o[IO_WIDTH_BIT] == $past(io_win_o.w32))
		else $error("window high bit 0 does not mirror width flag");
	a_fwd_decide: assert property (##1 io_fwd_hit_o == ($past(io_addr_i[31:16]) == 16'h0000
		&& $past(io_addr_i[15:12]) >= $past(io_win_o.base) && $past(io_addr_i[15:12]) <= $past(io_win_o.limit)))
		else $error("forward decision wrong");
	a_resv_zero: assert property (s_axi_rvalid_o && (s_q.rd_idx == IDX_IOLO || s_q.rd_idx == IDX_IOHI)
		|-> s_axi_rdata_o[31:8] == '0 && s_axi_rdata_o[3:1] == 3'h0)
		else $error("window reserved bits not zero");
	a_dstat_zero: assert property (s_axi_rvalid_o && s_q.rd_idx == IDX_DSTAT |-> s_axi_rdata_o == '0)
		else $error("downstream status not zero");
	a_ro_ignored: assert property (wr_fire && (s_q.wr_idx == IDX_HDR || s_q.wr_idx == IDX_PLT) |=> $stable(s_q.cfg))
		else $error("read-only write changed state");
	a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
		|-> ##2 s_axi_bvalid_o)
		else $error("write response late");

	// Answers stand until taken, and block new requests meanwhile
	a_bvalid_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i
		|=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped before taken");
	a_rvalid_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i
		|=> s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
		else $error("read response dropped before taken");
	a_bvalid_clears: assert property (s_axi_bvalid_o && s_axi_bready_i
		|=> !s_axi_bvalid_o)
		else $error("write response not released after take");
	a_rvalid_clears: assert property (s_axi_rvalid_o && s_axi_rready_i
		|=> !s_axi_rvalid_o)
		else $error("read response not released after take");
	a_write_blocked: assert property (s_axi_bvalid_o
		|-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write accepted while response pending");
	a_read_blocked: assert property (s_axi_rvalid_o
		|-> !s_axi_arready_o)
		else $error("read accepted while response pending");
	a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o
		|=> s_axi_rvalid_o)
		else $error("read response late");

	// Response codes follow the map
	a_unmapped_rresp: assert property (s_axi_rvalid_o && !idx_mapped(s_q.rd_idx)
		|-> s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == '0)
		else $error("unmapped read not refused");
	a_mapped_rresp: assert property (s_axi_rvalid_o && idx_mapped(s_q.rd_idx)
		|-> s_axi_rresp_o == RESP_OKAY)
		else $error("mapped read refused");
	a_write_okay: assert property (wr_fire && idx_mapped(s_q.wr_idx)
		|=> s_axi_bresp_o == RESP_OKAY)
		else $error("mapped write refused");
	a_write_slverr: assert property (wr_fire && !idx_mapped(s_q.wr_idx)
		|=> s_axi_bresp_o == RESP_SLVERR)
		else $error("unmapped write not refused");

	// Stored state moves only on a lane 0 write
	a_strobe_off_keep: assert property (wr_fire && !s_q.wr_strb[0]
		|=> $stable(s_q.cfg))
		else $error("write without lane 0 changed state");
	a_cfg_quiet: assert property (!wr_fire
		|=> $stable(s_q.cfg))
		else $error("state changed without a write");
	a_width_written: assert property (wr_lane0 && s_q.wr_idx == IDX_IOLO && !s_q.cfg.lock
		|=> io_win_o.w32 == $past(s_q.wr_data[IO_WIDTH_BIT]))
		else $error("width flag not written while unlocked");
	a_width_held: assert property (wr_lane0 && s_q.wr_idx == IDX_IOLO && s_q.cfg.lock
		|=> $stable(io_win_o.w32))
		else $error("width flag written while locked");
	a_lock_write: assert property (wr_lane0 && s_q.wr_idx == IDX_LOCK
		|=> s_q.cfg.lock == $past(s_q.wr_data[LOCK_BIT]))
		else $error("lock word not written");

	// Forwarding decision limits
	a_hit_upper: assert property (io_addr_i[31:16] != 16'h0000
		|=> !io_fwd_hit_o)
		else $error("forward hit above 64K");
	a_hit_empty: assert property (io_win_o.base > io_win_o.limit
		|=> !io_fwd_hit_o)
		else $error("forward hit with empty window");

	// Read data taken from the stored fields at the take
	a_iolo_read: assert property ($rose(s_axi_rvalid_o) && s_q.rd_idx == IDX_IOLO
		|-> s_axi_rdata_o[7:4] == $past(io_win_o.base) && s_axi_rdata_o[0] == $past(io_win_o.w32))
		else $error("window low read wrong");
	a_iohi_read: assert property ($rose(s_axi_rvalid_o) && s_q.rd_idx == IDX_IOHI
		|-> s_axi_rdata_o[7:4] == $past(io_win_o.limit))
		else $error("window high read wrong");
	a_upbus_read: assert property ($rose(s_axi_rvalid_o) && s_q.rd_idx == IDX_UPBUS
		|-> s_axi_rdata_o == {24'h000000, $past(up_bus_o)})
		else $error("upstream bus number read wrong");
	a_dnbus_read: assert property ($rose(s_axi_rvalid_o) && s_q.rd_idx == IDX_DNBUS
		|-> s_axi_rdata_o == {24'h000000, $past(dn_bus_o)})
		else $error("downstream bus number read wrong");
	a_hibus_read: assert property ($rose(s_axi_rvalid_o) && s_q.rd_idx == IDX_HIBUS
		|-> s_axi_rdata_o == {24'h000000, $past(hi_bus_o)})
		else $error("highest downstream bus read wrong");

	c_write_then_read: cover property (wr_fire ##[1:20] (s_axi_rvalid_o && s_axi_rready_i));
	c_locked_write: cover property (wr_fire && s_q.cfg.lock && s_q.wr_idx == IDX_IOLO);
	c_fwd_hit: cover property (io_fwd_hit_o);
	c_unmapped: cover property (s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR);
	c_empty_window: cover property (io_win_o.base > io_win_o.limit);

endmodule // br1_hdr_regs

// ==== br1_hdr_regs_test.sv ====
// Purpose: Self-checking bench for the bridge header register window
// Assumes: Byte address is the register index times four; AXI answer timing comes from the design
// Notes: Behavioural model is updated at each answered write and compared at every read
`timescale 1ns/100ps
module bridge_type1_header_bus_io_window_test;
	import br1_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, io_addr = 32'h0, rdata;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, hit;
	logic [1:0] bresp, rresp;
	br1_iowin_t win;
	logic [7:0] up_o, dn_o, hi_o, m_up, m_dn, m_hi;
	logic [3:0] m_base, m_lim;
	logic m_w32, m_lock;
	logic [15:0] seed = 16'h4474;
	int n_errors = 0;
	int comparisons = 0;

	br1_hdr_regs br1_hdr_regs_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
		.s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.io_addr_i(io_addr), .io_win_o(win), .up_bus_o(up_o), .dn_bus_o(dn_o), .hi_bus_o(hi_o),
		.io_fwd_hit_o(hit));

	initial begin
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic [1:0] exp_resp(input logic [5:0] i);
		return (i inside {[6'h0D:6'h10], 6'h14, [6'h18:6'h1E], 6'h3F}) ? RESP_OKAY : RESP_SLVERR;
	endfunction

	function automatic logic [31:0] exp_rd(input logic [5:0] i);
		case (i)
			6'h0E: return 32'h01;
			6'h18: return {24'h0, m_up};
			6'h19: return {24'h0, m_dn};
			6'h1A: return {24'h0, m_hi};
			6'h1C: return {24'h0, m_base, 3'h0, m_w32};
			6'h1D: return {24'h0, m_lim, 3'h0, m_w32};
			6'h3F: return {31'h0, m_lock};
			default: return 32'h0;
		endcase
	endfunction

	task automatic mdl_reset;
		{m_up, m_dn, m_hi, m_base, m_lim, m_w32, m_lock} = {24'h0, 4'hF, 4'h0, 1'b1, 1'b0};
	endtask

	task automatic mdl_wr(input logic [5:0] i, input logic [31:0] d, input logic [3:0] st);
		if (st[0]) begin
			case (i)
				6'h18: m_up = d[7:0];
				6'h19: m_dn = d[7:0];
				6'h1A: m_hi = d[7:0];
				6'h1C: begin
					m_base = d[7:4];
					if (!m_lock) m_w32 = d[0];
				end
				6'h1D: m_lim = d[7:4];
				6'h3F: m_lock = d[0];
				default: ;
			endcase
		end
	endtask

	task automatic end_sim;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp);
		chk_val({31'h0, got}, {31'h0, exp});
	endtask

	task automatic timeout;
		n_errors++;
		$display("unexpected at %0t: no answer, got %h expected %h", $time, 1'b0, 1'b1);
		end_sim();
	endtask

	task automatic axi_wr(input logic [5:0] i, input logic [31:0] d, input logic [3:0] st);
		int n;
		@(posedge clk_sys_i);
		awaddr <= {i, 2'b00};
		wdata <= d;
		wstrb <= st;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_sys_i);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		if (n == 50) timeout();
		chk_val({30'h0, bresp}, {30'h0, exp_resp(i)});
		mdl_wr(i, d, st);
	endtask

	task automatic axi_rd(input logic [5:0] i, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk_sys_i);
		araddr <= {i, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_sys_i);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n == 50) timeout();
	endtask

	task automatic read_all;
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 64; i++) begin
			axi_rd(i[5:0], d, r);
			chk_val(d, exp_rd(i[5:0]));
			chk_val({30'h0, r}, {30'h0, exp_resp(i[5:0])});
		end
		chk_val({23'h0, win}, {23'h0, m_base, m_lim, m_w32});
		chk_val({8'h0, up_o, dn_o, hi_o}, {8'h0, m_up, m_dn, m_hi});
	endtask

	// Upper half nonzero now and then, since the window only covers the low 64K
	task automatic fwd_check(input int count);
		logic [31:0] a;
		for (int k = 0; k < count; k++) begin
			seed = lfsr(seed);
			a = {(k % 4 == 0) ? seed : 16'h0, lfsr(seed)};
			io_addr <= a;
			repeat (2) @(posedge clk_sys_i);
			chk_flag(hit, a[31:16] == 16'h0 && a[15:12] >= m_base && a[15:12] <= m_lim);
		end
	endtask

	initial begin
		mdl_reset();
		repeat (20) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		read_all();
		fwd_check(20);
		for (int p = 0; p < 3; p++) begin
			for (int i = 0; i < 64; i++) begin
				seed = lfsr(seed);
				axi_wr(i[5:0], {seed, lfsr(seed)}, seed[7:4]);
			end
			read_all();
			fwd_check(40);
		end
		axi_wr(6'h3F, 32'h1, 4'hF);
		axi_wr(6'h1C, 32'hA0, 4'hF);
		axi_wr(6'h1C, 32'hA1, 4'hF);
		read_all();
		axi_wr(6'h3F, 32'h0, 4'hF);
		axi_wr(6'h1C, 32'h2E, 4'hF);
		axi_wr(6'h1D, 32'h5F, 4'hF);
		read_all();
		fwd_check(48);
		// Second reset in mid-run must restore every reset value
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		mdl_reset();
		rst_i <= 1'b0;
		read_all();
		end_sim();
	end
endmodule // bridge_type1_header_bus_io_window_test

// ==== br1_pkg.sv ====
// Purpose: Shared constants and types for the bridge header register window
// Assumes: Register indices are word indices; byte address is index times four
// Notes: The header range from the primary latency timer to downstream status, plus the lock word at index 0x3F
package br1_pkg;
	localparam int unsigned IDX_W = 6;
	localparam int unsigned DATA_W = 32;
	// Register indices, byte address = index * 4
	localparam logic [IDX_W-1:0] IDX_PLT = 6'h0D;
	localparam logic [IDX_W-1:0] IDX_HDR = 6'h0E;
	localparam logic [IDX_W-1:0] IDX_SELFTEST = 6'h0F;
	localparam logic [IDX_W-1:0] IDX_BASE0 = 6'h10;
	localparam logic [IDX_W-1:0] IDX_BASE1 = 6'h14;
	localparam logic [IDX_W-1:0] IDX_UPBUS = 6'h18;
	localparam logic [IDX_W-1:0] IDX_DNBUS = 6'h19;
	localparam logic [IDX_W-1:0] IDX_HIBUS = 6'h1A;
	localparam logic [IDX_W-1:0] IDX_DLT = 6'h1B;
	localparam logic [IDX_W-1:0] IDX_IOLO = 6'h1C;
	localparam logic [IDX_W-1:0] IDX_IOHI = 6'h1D;
	localparam logic [IDX_W-1:0] IDX_DSTAT = 6'h1E;
	localparam logic [IDX_W-1:0] IDX_LOCK = 6'h3F;
	// Field positions
	localparam int unsigned IO_WIDTH_BIT = 0;
	localparam int unsigned IO_ADDR_LSB = 4;
	localparam int unsigned LOCK_BIT = 0;
	// Reset and constant values
	localparam logic [7:0] VAL_HDR = 8'h01;
	localparam logic [7:0] RST_BUS = 8'h00;
	localparam logic [3:0] RST_IO_BASE = 4'hF;
	localparam logic [3:0] RST_IO_LIMIT = 4'h0;
	localparam logic RST_IO_W32 = 1'b1;
	localparam logic RST_LOCK = 1'b0;
	localparam logic [11:0] IO_LIMIT_LOW = 12'hFFF;
	localparam logic [11:0] IO_BASE_LOW = 12'h000;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [7:0] up_bus;
		logic [7:0] dn_bus;
		logic [7:0] hi_bus;
		logic [3:0] io_base;
		logic [3:0] io_limit;
		logic io_w32;
		logic lock;
	} br1_cfg_t;

	typedef struct packed {
		logic [3:0] base;
		logic [3:0] limit;
		logic w32;
	} br1_iowin_t;

	typedef struct packed {
		br1_cfg_t cfg;
		logic aw_rdy;
		logic w_rdy;
		logic aw_hold;
		logic w_hold;
		logic [IDX_W-1:0] wr_idx;
		logic [DATA_W-1:0] wr_data;
		logic [3:0] wr_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic ar_rdy;
		logic rvalid;
		logic [IDX_W-1:0] rd_idx;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
		logic fwd_hit;
	} br1_state_t;
endpackage
